// ===== sarq_defs.vh
/*
 * constants for the sar conversion sequencer: widths, codes, timing.
 * assumes a 50 MHz mclk; included by the sequencer and its testbench only.
 */
`ifndef SARQ_DEFS_VH
`define SARQ_DEFS_VH

// ************************************************************
// code format
// ************************************************************
`define SARQ_BITS        18
`define SARQ_CODE_ZERO   18'h00000
`define SARQ_CODE_MAX    18'h1ffff
`define SARQ_CODE_MIN    18'h20000
`define SARQ_MSB_FLIP    18'h20000

// ************************************************************
// timing (mclk 50 MHz)
// ************************************************************
`define SARQ_MCLK_MHZ    50
`define SARQ_SETTLE_NS   40
`define SARQ_SETTLE_CYC  ((`SARQ_SETTLE_NS * `SARQ_MCLK_MHZ + 999) / 1000)
// three mclk per bit: the comparator reading passes two sync flops
// after the dac moves, so a shorter step would judge the previous trial
`define SARQ_CONV_DIV    3
`define SARQ_ACQ_MIN_CYC 8

`endif

// ===== sarq_result_reg.v
/*
 * holds the last finished output code; read data come from a register.
 * assumes one write strobe per conversion, same clock as the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none

module sarq_result_reg #(
    parameter WIDTH = 18
) (
    // clock and reset
    input  wire             mclk,
    input  wire             reset,
    // write side
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    // read side
    output reg  [WIDTH-1:0] rd_data_q
);

// ************************************************************
// storage
// ************************************************************
// result word, reset to zero code
always @(posedge mclk) begin
    if (reset) begin
        rd_data_q <= {WIDTH{1'b0}};
    end else if (wr_en) begin
        rd_data_q <= wr_data;
    end
end

endmodule
`default_nettype wire

// ===== sarq_sequencer.v
/*
 * control logic of an 18-bit successive approximation converter:
 * sampling switches, binary search over the capacitor dac, output code.
 * assumes comparator and range detector are asynchronous analog
 * macros whose outputs are sampled through two flip-flops here, and that
 * convert_strobe arrives asynchronously from host logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sarq_defs.vh"

module sarq_sequencer #(
    parameter NBITS    = `SARQ_BITS,
    parameter CONV_DIV = `SARQ_CONV_DIV
) (
    // clock and reset
    input  wire             mclk,
    input  wire             reset,
    // host strobe (asynchronous)
    input  wire             convert_strobe,
    // analog front end status (asynchronous)
    input  wire             comp_keep,
    input  wire             over_range,
    input  wire             under_range,
    // analog switch controls
    output reg              pos_comparator_ground_switch_q,
    output reg              neg_comparator_ground_switch_q,
    output reg              array_to_input_q,
    output reg  [NBITS-1:0] dac_ref_sel_q,
    output reg              analog_power_q,
    // results
    output reg              busy_q,
    output reg              data_valid_q,
    output wire [NBITS-1:0] code_q
);

// ************************************************************
// states and constants
// ************************************************************
localparam [2:0] ST_ACQ    = 3'd0;
localparam [2:0] ST_OPENSW = 3'd1;
localparam [2:0] ST_HOLD   = 3'd2;
localparam [2:0] ST_BIT    = 3'd3;
localparam [2:0] ST_DONE   = 3'd4;
// counts are cut to the 8-bit counter width on purpose
localparam [31:0] SETTLE_W   = `SARQ_SETTLE_CYC;
localparam [31:0] DIV_LAST_W = CONV_DIV - 1;
localparam [31:0] ACQ_W      = `SARQ_ACQ_MIN_CYC;
localparam [7:0]  SETTLE_CYC = SETTLE_W[7:0];
localparam [7:0]  DIV_LAST   = DIV_LAST_W[7:0];
localparam [7:0]  ACQ_CYC    = ACQ_W[7:0];

// ************************************************************
// input synchronisers
// ************************************************************
reg [1:0] cnv_sync_q;
reg [1:0] cmp_sync_q;
reg [1:0] ovr_sync_q;
reg [1:0] und_sync_q;
reg       cnv_last_q;

// two flops each; only the second stage is read by logic
always @(posedge mclk) begin
    if (reset) begin
        cnv_sync_q <= 2'b00;
        cmp_sync_q <= 2'b00;
        ovr_sync_q <= 2'b00;
        und_sync_q <= 2'b00;
        cnv_last_q <= 1'b0;
    end else begin
        cnv_sync_q <= {cnv_sync_q[0], convert_strobe};
        cmp_sync_q <= {cmp_sync_q[0], comp_keep};
        ovr_sync_q <= {ovr_sync_q[0], over_range};
        und_sync_q <= {und_sync_q[0], under_range};
        cnv_last_q <= cnv_sync_q[1];
    end
end

wire cnv_rise = cnv_sync_q[1] & ~cnv_last_q;

// ************************************************************
// output code formation
// ************************************************************
// turn offset-binary trial word into the saturated output code
function [NBITS-1:0] form_code;
    input [NBITS-1:0] raw;
    input             ovr;
    input             und;
    begin
        if (ovr) begin
            form_code = `SARQ_CODE_MAX;
        end else if (und) begin
            form_code = `SARQ_CODE_MIN;
        end else begin
            form_code = raw ^ `SARQ_MSB_FLIP;
        end
    end
endfunction

// ************************************************************
// sequencer
// ************************************************************
reg [2:0]             state_q;
reg [7:0]             cnt_q;
reg [4:0]             bit_q;
reg                   ovr_cap_q;
reg                   und_cap_q;
reg                   wr_q;
reg [NBITS-1:0]       wr_data_q;
reg                   acq_ok_q;

// one-cycle enable from a divider paces the bit decisions
// internal pacing divider
wire conv_tick = (cnt_q == DIV_LAST);

always @(posedge mclk) begin
    if (reset) begin
        state_q                        <= ST_ACQ;
        cnt_q                          <= 8'h00;
        bit_q                          <= 5'h00;
        pos_comparator_ground_switch_q <= 1'b1;
        neg_comparator_ground_switch_q <= 1'b1;
        array_to_input_q               <= 1'b1;
        dac_ref_sel_q                  <= {NBITS{1'b0}};
        analog_power_q                 <= 1'b0;
        busy_q                         <= 1'b0;
        data_valid_q                   <= 1'b0;
        ovr_cap_q                      <= 1'b0;
        und_cap_q                      <= 1'b0;
        wr_q                           <= 1'b0;
        wr_data_q                      <= {NBITS{1'b0}};
        acq_ok_q                       <= 1'b0;
    end else begin
        wr_q         <= 1'b0;
        data_valid_q <= 1'b0;
        case (state_q)
            ST_ACQ: begin
                // acquisition must last a minimum before a start counts
                if (cnt_q != ACQ_CYC) begin
                    cnt_q <= cnt_q + 8'h01;
                end else begin
                    acq_ok_q <= 1'b1;
                end
                if (cnv_rise && acq_ok_q) begin
                    pos_comparator_ground_switch_q <= 1'b0;
                    neg_comparator_ground_switch_q <= 1'b0;
                    analog_power_q <= 1'b1;
                    busy_q         <= 1'b1;
                    acq_ok_q       <= 1'b0;
                    cnt_q          <= 8'h00;
                    state_q        <= ST_OPENSW;
                end
            end
            ST_OPENSW: begin
                // switches must settle before arrays leave the inputs
                if (cnt_q == SETTLE_CYC - 8'h01) begin
                    array_to_input_q <= 1'b0;
                    cnt_q            <= 8'h00;
                    state_q          <= ST_HOLD;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            ST_HOLD: begin
                if (cnt_q == SETTLE_CYC - 8'h01) begin
                    dac_ref_sel_q <= {1'b1, {(NBITS-1){1'b0}}};
                    bit_q         <= NBITS[4:0] - 5'h01;
                    cnt_q         <= 8'h00;
                    state_q       <= ST_BIT;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            ST_BIT: begin
                if (conv_tick) begin
                    cnt_q <= 8'h00;
                    if (!cmp_sync_q[1]) begin
                        dac_ref_sel_q[bit_q] <= 1'b0;
                    end
                    if (bit_q != 5'h00) begin
                        dac_ref_sel_q[bit_q - 5'h01] <= 1'b1;
                        bit_q <= bit_q - 5'h01;
                    end else begin
                        ovr_cap_q <= ovr_sync_q[1];
                        und_cap_q <= und_sync_q[1];
                        state_q   <= ST_DONE;
                    end
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            ST_DONE: begin
                wr_data_q <= form_code(dac_ref_sel_q, ovr_cap_q, und_cap_q);
                wr_q <= 1'b1;
                pos_comparator_ground_switch_q <= 1'b1;
                neg_comparator_ground_switch_q <= 1'b1;
                array_to_input_q               <= 1'b1;
                dac_ref_sel_q                  <= {NBITS{1'b0}};
                analog_power_q <= 1'b0;
                cnt_q          <= 8'h00;
                state_q        <= ST_ACQ;
            end
            default: begin
                state_q <= ST_ACQ;
            end
        endcase
        // busy drops together with valid, on the same edge that writes the result register
        if (wr_q) begin
            busy_q       <= 1'b0;
            data_valid_q <= 1'b1;
        end
    end
end

// ************************************************************
// result storage
// ************************************************************
// latest result only
sarq_result_reg #(
    .WIDTH (NBITS)
) u_result (
    .mclk      (mclk),
    .reset     (reset),
    .wr_en     (wr_q),
    .wr_data   (wr_data_q),
    .rd_data_q (code_q)
);

endmodule
`default_nettype wire

// ===== sarq_seq_assertions.sv
/* port checker for the sar sequencer.
   assumes a bind onto sarq_sequencer, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module sarq_seq_assertions #(
    parameter NBITS    = 18,
    parameter CONV_DIV = 3
) (
    // clock and reset
    input wire logic             mclk,
    input wire logic             reset,
    // switch controls
    input wire logic             pos_comparator_ground_switch_q,
    input wire logic             neg_comparator_ground_switch_q,
    input wire logic             array_to_input_q,
    input wire logic [NBITS-1:0] dac_ref_sel_q,
    input wire logic             analog_power_q,
    // results
    input wire logic             busy_q,
    input wire logic             data_valid_q,
    input wire logic [NBITS-1:0] code_q
);
    // ************************************************************
    // port relations
    // ************************************************************
    // busy to result: 2 + 2 settle, one step per bit, then done and write
    localparam int CONV_CYC = 6 + NBITS * CONV_DIV;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_start_opens_sw: assert property (
        $rose(busy_q) |-> !pos_comparator_ground_switch_q && !neg_comparator_ground_switch_q)
        else $error("ground switches still closed at start");
    a_array_after_sw: assert property (
        $fell(array_to_input_q) |-> $past(pos_comparator_ground_switch_q, 2) == 1'b0)
        else $error("arrays left inputs before switches opened");
    a_msb_first: assert property (
        $fell(array_to_input_q) |-> ##2 dac_ref_sel_q == 18'h20000)
        else $error("first trial is not the top weight");
    // the count from busy to result is fixed once a start is taken
    a_conv_time: assert property (
        $rose(busy_q) |-> ##[CONV_CYC:CONV_CYC] data_valid_q)
        else $error("conversion did not finish in time");
    a_valid_ends_busy: assert property (
        data_valid_q |-> !busy_q && $past(busy_q))
        else $error("result pulse not at busy end");
    a_power_down: assert property (
        !busy_q |-> !analog_power_q)
        else $error("analog powered while idle");
    a_idle_acquire: assert property (
        !busy_q |-> array_to_input_q && dac_ref_sel_q == 0 && pos_comparator_ground_switch_q)
        else $error("not back in acquisition while idle");
    a_code_holds: assert property (
        !data_valid_q && !$past(reset) |-> $stable(code_q))
        else $error("code changed without a result pulse");
endmodule
`default_nettype wire

// ===== sarq_host_model.sv
/* host and comparator model facing the sar sequencer.
   assumes the bench sets go and the sampled target value. */
`timescale 1ns/1ps
`default_nettype none
module sarq_host_model (
    // clock
    input wire logic        mclk,
    // bench control
    input wire logic        go,
    input wire logic [17:0] target,
    // design side
    input wire logic [17:0] dac_ref_sel_q,
    output var logic        convert_strobe = 1'b0,
    output wire logic       comp_keep
);
    always @(posedge mclk) begin
        convert_strobe <= go;
    end
    // keep while the dac is not above the held sample
    assign comp_keep = (dac_ref_sel_q <= (target ^ 18'h20000));
endmodule
`default_nettype wire

// ===== sar_conversion_sequencer_tb.sv
/* self-checking bench for the sar sequencer.
   assumes sarq_defs.vh, the checker and the host model. */
`timescale 1ns/1ps
`default_nettype none
`include "sarq_defs.vh"
module sar_conversion_sequencer_tb;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        go = 1'b0;
    logic        ovr = 1'b0;
    logic        und = 1'b0;
    logic [17:0] target = 18'h0;
    logic        strobe, keep, pos_sw, neg_sw, arr_in, power, busy, valid;
    logic [17:0] dac, code;
    int          n_fail = 0;
    int          checks = 0;
    int          n_valid = 0;
    always #10 mclk = ~mclk;
    sarq_host_model sarq_host_model_i (.mclk(mclk), .go(go), .target(target),
        .dac_ref_sel_q(dac), .convert_strobe(strobe), .comp_keep(keep));
    sarq_sequencer sarq_sequencer_i (.mclk(mclk), .reset(reset), .convert_strobe(strobe),
        .comp_keep(keep), .over_range(ovr), .under_range(und),
        .pos_comparator_ground_switch_q(pos_sw), .neg_comparator_ground_switch_q(neg_sw),
        .array_to_input_q(arr_in), .dac_ref_sel_q(dac), .analog_power_q(power),
        .busy_q(busy), .data_valid_q(valid), .code_q(code));
    // ************************************************************
    // checks and helpers
    // ************************************************************
    always @(negedge mclk) begin
        if (valid === 1'b1) n_valid++;
    end
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // bounded wait so a missing pulse cannot hang the run
    task automatic wait_valid;
        for (int k = 0; k < 100 && valid !== 1'b1; k++) @(negedge mclk);
        // a pulse that never came counts as a mismatch
        chk({17'h0, valid}, 18'h1);
    endtask
    // one conversion; strobe stays up until the result pulse
    task automatic conv(input logic [17:0] t, input logic ov, un, input logic [17:0] exp);
        @(negedge mclk);
        target = t;
        ovr = ov;
        und = un;
        go = 1'b1;
        wait_valid;
        chk(code, exp);
        chk({17'h0, busy}, 18'h0);
        go = 1'b0;
        repeat (12) @(negedge mclk);
    endtask
    // extra strobe edges mid conversion and in minimum acquisition
    task automatic t_refused;
        int v0;
        v0 = n_valid;
        conv(18'h0aaaa, 1'b0, 1'b0, 18'h0aaaa);
        @(negedge mclk);
        go = 1'b1;
        repeat (20) @(negedge mclk);
        go = 1'b0;
        repeat (2) @(negedge mclk);
        go = 1'b1;
        wait_valid;
        go = 1'b0;
        repeat (2) @(negedge mclk);
        go = 1'b1;
        repeat (60) @(negedge mclk);
        chk(18'(n_valid - v0), 18'h2);
        chk({17'h0, busy}, 18'h0);
        go = 1'b0;
        repeat (12) @(negedge mclk);
    endtask
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    // idle outputs right after reset release
    task automatic t_reset;
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        chk({12'h0, pos_sw, neg_sw, arr_in, power, busy, valid}, 18'h38);
        chk(code, `SARQ_CODE_ZERO);
        repeat (10) @(negedge mclk);
    endtask
    // in-range samples across the whole span
    task automatic t_codes;
        logic [17:0] tv [7];
        tv = '{18'h00000, 18'h3ffff, 18'h20000, 18'h1ffff, 18'h00001, 18'h20001, 18'h15555};
        for (int i = 0; i < 7; i++) conv(tv[i], 1'b0, 1'b0, tv[i]);
    endtask
    // range flags saturate, over-range wins when both are up
    task automatic t_range;
        conv(18'h00000, 1'b1, 1'b0, `SARQ_CODE_MAX);
        conv(18'h00000, 1'b0, 1'b1, `SARQ_CODE_MIN);
        conv(18'h12345, 1'b1, 1'b1, `SARQ_CODE_MAX);
    endtask
    initial begin
        t_reset;
        t_codes;
        t_range;
        t_refused;
        stop_test;
    end
    initial begin
        #100000;
        n_fail++;
        stop_test;
    end
endmodule
bind sarq_sequencer sarq_seq_assertions #(.NBITS(NBITS), .CONV_DIV(CONV_DIV))
    sarq_seq_assertions_i (.mclk(mclk), .reset(reset),
    .pos_comparator_ground_switch_q(pos_comparator_ground_switch_q),
    .neg_comparator_ground_switch_q(neg_comparator_ground_switch_q),
    .array_to_input_q(array_to_input_q), .dac_ref_sel_q(dac_ref_sel_q),
    .analog_power_q(analog_power_q), .busy_q(busy_q), .data_valid_q(data_valid_q),
    .code_q(code_q));
`default_nettype wire
